// File: core/crma_map.vh
// Constants for the compare / rotate-and-mask execution slice.
// Assumes a 32-bit core with big-endian bit numbering in its documentation.
// Function
// - Compare writes one-hot less/greater/same to field.
// - Compare copies sticky overflow into field bit.
// - Signed compares sign-extend immediate, compare signed.
// - Unsigned compares zero-extend immediate, compare unsigned.
// - First quantity from source; second register or immediate.
// - Rotate left, bits wrap from top to bottom.
// - Record flag updates first condition field only.
// - Rotates leave exception register untouched.
// - Rotate reads source register, writes destination register.
// - Mask from two 5-bit begin/end fields.
// - Ones from begin through end, bit 0 most significant.
// - Begin above end wraps ones around.
// - Mask is never all zero.
// - Immediate rotate amount, AND mask, write destination.
// - Register rotate amount, AND mask, write destination.
`ifndef CRMA_MAP_VH
`define CRMA_MAP_VH
`define CRMA_OP_SCMP 3'h0
`define CRMA_OP_SCMPI 3'h1
`define CRMA_OP_UCMP 3'h2
`define CRMA_OP_UCMPI 3'h3
`define CRMA_OP_ROTI 3'h4
`define CRMA_OP_ROTR 3'h5
`define CRMA_FLD_LESS 2'h3
`define CRMA_FLD_GREATER 2'h2
`define CRMA_FLD_SAME 2'h1
`define CRMA_FLD_STICKY 2'h0
`define CRMA_FIRST_FIELD 3'h0
`define CRMA_FIELD0_LSB 5'h1c
`define CRMA_CR_RESET 32'h00000000
`define CRMA_GPR_RESET 32'h00000000
`define CRMA_LATENCY 1
`endif

// File: core/crma_mask_gen.v
// Rotate mask generator: ones from begin to end, big-endian bit numbers.
// Assumes begin and end are 5-bit instruction fields.
`default_nettype none
module crma_mask_gen #(
	parameter WIDTH = 32
) (
	input wire [4:0] maskBegin,
	input wire [4:0] maskEnd,
	output reg [WIDTH-1:0] mask
);
	integer i;
	reg [4:0] pos;
	// Position p is bit WIDTH-1-p in little-endian terms
	always @* begin
		pos = 5'h00;
		mask = {WIDTH{1'b0}};
		for (i = 0; i < WIDTH; i = i + 1) begin
			pos = i[4:0];
			if (maskBegin <= maskEnd)
				mask[WIDTH-1-i] = (pos >= maskBegin) && (pos <= maskEnd);
			else
				mask[WIDTH-1-i] = (pos >= maskBegin) || (pos <= maskEnd);
		end
	end
endmodule
`default_nettype wire

// File: core/crma_alu.v
// Compare and rotate-then-AND-with-mask execution slice with its register file.
// Assumes the decoder presents one operation per issue pulse, fields already split.
`include "crma_map.vh"
`default_nettype none
module crma_alu #(
	parameter WIDTH = 32,
	parameter NREGS = 32
) (
	input wire ref_clk,
	input wire rstn,
	input wire issue,
	input wire [2:0] opcode,
	input wire operandSizeBit,
	input wire [2:0] crDestField,
	input wire [4:0] destReg,
	input wire [4:0] srcWordReg,
	input wire [4:0] secondOperandReg,
	input wire [15:0] immField,
	input wire [4:0] rotateAmountImm,
	input wire [4:0] maskBegin,
	input wire [4:0] maskEnd,
	input wire recordFlag,
	input wire stickyOverflowIn,
	input wire rfWrite,
	input wire [4:0] rfWriteAddr,
	input wire [WIDTH-1:0] rfWriteData,
	input wire [4:0] rfReadAddr,
	output reg [WIDTH-1:0] rfReadData,
	output reg [31:0] condFlags,
	output reg [WIDTH-1:0] resultData,
	output reg resultValid,
	output reg badOperandSize
);
	reg [WIDTH-1:0] gprFile [0:NREGS-1];
	reg [31:0] condFlags_reg;
	wire [31:0] condFlags_next;
	wire [WIDTH-1:0] mask;
	wire [WIDTH-1:0] srcA = gprFile[srcWordReg];
	wire [WIDTH-1:0] srcB = gprFile[secondOperandReg];
	wire isCmp = (opcode == `CRMA_OP_SCMP) || (opcode == `CRMA_OP_SCMPI) ||
		(opcode == `CRMA_OP_UCMP) || (opcode == `CRMA_OP_UCMPI);
	wire isRot = (opcode == `CRMA_OP_ROTI) || (opcode == `CRMA_OP_ROTR);
	reg [WIDTH-1:0] cmpB;
	reg cmpSigned;
	reg cmpLess;
	reg cmpGreater;
	reg [4:0] rotAmt;
	reg [2*WIDTH-1:0] rotDouble;
	reg [WIDTH-1:0] rotWord;
	reg [WIDTH-1:0] rotResult;
	reg [3:0] newField;
	wire [7:0] destSel = 8'h01 << crDestField;
	wire [7:0] firstSel = 8'h01 << `CRMA_FIRST_FIELD;
	wire cmpWrite = issue && isCmp;
	wire recWrite = issue && isRot && recordFlag;
	genvar f;

	crma_mask_gen #(
		.WIDTH(WIDTH)
	) maskGen (
		.maskBegin(maskBegin),
		.maskEnd(maskEnd),
		.mask(mask)
	);

	// Second operand and signedness
	always @* begin
		cmpB = srcB;
		cmpSigned = 1'b0;
		case (opcode)
			`CRMA_OP_SCMP: begin
				cmpSigned = 1'b1;
			end
			`CRMA_OP_SCMPI: begin
				cmpB = {{(WIDTH-16){immField[15]}}, immField};
				cmpSigned = 1'b1;
			end
			`CRMA_OP_UCMPI: begin
				cmpB = {{(WIDTH-16){1'b0}}, immField};
			end
			default: begin
				cmpB = srcB;
			end
		endcase
	end

	// Rotate left with wrap, then mask
	always @* begin
		if (opcode == `CRMA_OP_ROTR)
			rotAmt = srcB[4:0];
		else
			rotAmt = rotateAmountImm;
		rotDouble = {srcA, srcA} << rotAmt;
		rotWord = rotDouble[2*WIDTH-1:WIDTH];
		rotResult = rotWord & mask;
	end

	// Comparison outcome for compares and recording rotates
	always @* begin
		if (isRot) begin
			cmpLess = rotResult[WIDTH-1];
			cmpGreater = !rotResult[WIDTH-1] && (rotResult != {WIDTH{1'b0}});
		end else if (cmpSigned) begin
			cmpLess = $signed(srcA) < $signed(cmpB);
			cmpGreater = $signed(srcA) > $signed(cmpB);
		end else begin
			cmpLess = srcA < cmpB;
			cmpGreater = srcA > cmpB;
		end
		newField[`CRMA_FLD_LESS] = cmpLess;
		newField[`CRMA_FLD_GREATER] = cmpGreater;
		newField[`CRMA_FLD_SAME] = !cmpLess && !cmpGreater;
		newField[`CRMA_FLD_STICKY] = stickyOverflowIn;
	end

	// One write enable per condition field; field 0 holds the top nibble
	generate
		for (f = 0; f < 8; f = f + 1) begin : fieldUpd
			localparam LSB = `CRMA_FIELD0_LSB - 4 * f;
			wire fieldHit = (cmpWrite && destSel[f]) || (recWrite && firstSel[f]);
			assign condFlags_next[LSB +: 4] = fieldHit ? newField : condFlags_reg[LSB +: 4];
		end
	endgenerate

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			condFlags_reg <= `CRMA_CR_RESET;
			resultData <= `CRMA_GPR_RESET;
			resultValid <= 1'b0;
			badOperandSize <= 1'b0;
		end else begin
			condFlags_reg <= condFlags_next;
			resultValid <= issue && isRot;
			badOperandSize <= issue && isCmp && operandSizeBit;
			if (issue && isRot)
				resultData <= rotResult;
		end
	end

	// Register file; rotate write takes priority over external write port
	always @(posedge ref_clk) begin
		if (issue && isRot)
			gprFile[destReg] <= rotResult;
		else if (rfWrite)
			gprFile[rfWriteAddr] <= rfWriteData;
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			rfReadData <= `CRMA_GPR_RESET;
		else
			rfReadData <= gprFile[rfReadAddr];
	end

	always @* begin
		condFlags = condFlags_reg;
	end
endmodule
`default_nettype wire

// File: bench/crma_alu_monitor.sv
// Port-level checker for the compare / rotate-and-mask slice.
// Assumes it is bound to crma_alu on one clock and reset.
`default_nettype none
module crma_alu_monitor (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic issue,
	input wire logic [2:0] opcode,
	input wire logic [2:0] crDestField,
	input wire logic recordFlag,
	input wire logic stickyOverflowIn,
	input wire logic [31:0] condFlags,
	input wire logic [31:0] resultData,
	input wire logic resultValid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire logic rotIssue = issue && opcode[2:1] == 2'h2;
	wire logic cmpField0 = issue && !opcode[2] && crDestField == 3'h0;
	a_rot_valid: assert property (rotIssue |=> resultValid)
		else $error("no result pulse");
	a_no_stray: assert property (!rotIssue |=> !resultValid)
		else $error("stray result pulse");
	a_cmp_onehot: assert property (cmpField0 |=> $onehot(condFlags[31:29]))
		else $error("flags not one-hot");
	a_cmp_sticky: assert property (cmpField0 |=> condFlags[28] == $past(stickyOverflowIn))
		else $error("sticky not copied");
	a_norec_hold: assert property (rotIssue && !recordFlag |=> $stable(condFlags))
		else $error("flags changed");
	a_idle_hold: assert property (!issue |=> $stable(condFlags))
		else $error("flags changed idle");
	a_rec_same: assert property (rotIssue && recordFlag |=> condFlags[29] == ~|resultData)
		else $error("zero flag wrong");
	a_rec_less: assert property (rotIssue && recordFlag |=> condFlags[31] == resultData[31])
		else $error("sign flag wrong");
endmodule
bind crma_alu crma_alu_monitor mon_u (.ref_clk, .rstn, .issue, .opcode, .crDestField,
	.recordFlag, .stickyOverflowIn, .condFlags, .resultData, .resultValid);
`default_nettype wire

// File: bench/crma_dec_model.sv
// Decoder-side model: exception register sticky bit and size bit.
// Assumes the bench commands the sticky level.
`default_nettype none
module crma_dec_model (
	input wire logic ref_clk,
	input wire logic setSticky,
	output var logic stickyOverflowIn,
	output var logic operandSizeBit
);
	timeunit 1ns;
	timeprecision 1ns;
	initial stickyOverflowIn = 1'h0;
	always @(posedge ref_clk) stickyOverflowIn <= setSticky;
	assign operandSizeBit = 1'h0;
endmodule
`default_nettype wire

// File: bench/test_compare_rotate_mask_alu.sv
// Self-checking bench for the compare / rotate-and-mask slice.
// Assumes crma_alu with built-in register file and the decoder model.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t got %h", $time, a); end end
module test_compare_rotate_mask_alu;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rstn = 0, issue = 0, recordFlag = 0, rfWrite = 0, setSticky = 1;
	logic [2:0] opcode = '0, crDestField = '0;
	logic [4:0] destReg = '0, srcWordReg = '0, secondOperandReg = '0, rotateAmountImm = '0;
	logic [4:0] maskBegin = '0, maskEnd = '0, rfWriteAddr = '0, rfReadAddr = '0;
	logic [15:0] immField = 16'hfffe;
	logic [31:0] rfWriteData = '0;
	wire logic [31:0] rfReadData, condFlags, resultData;
	wire logic resultValid, stickyOverflowIn, operandSizeBit, badOperandSize;
	int fails = 0, checked = 0;
	crma_dec_model dec_u (.ref_clk, .setSticky, .stickyOverflowIn, .operandSizeBit);
	crma_alu dut_u (.ref_clk, .rstn, .issue, .opcode, .operandSizeBit, .crDestField, .destReg,
		.srcWordReg, .secondOperandReg, .immField, .rotateAmountImm, .maskBegin, .maskEnd,
		.recordFlag, .stickyOverflowIn, .rfWrite, .rfWriteAddr, .rfWriteData, .rfReadAddr,
		.rfReadData, .condFlags, .resultData, .resultValid, .badOperandSize);
	initial forever #5 ref_clk = ~ref_clk;
	task go(input logic [2:0] o);
		issue = 1;
		opcode = o;
		@(negedge ref_clk);
		`CHK(resultValid, o == 3'h4 || o == 3'h5)
		`CHK(badOperandSize, 1'b0)
		issue = 0;
		@(negedge ref_clk);
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		rfWrite = 1;
		rfWriteAddr = a;
		rfWriteData = d;
		@(negedge ref_clk);
		rfWrite = 0;
		@(negedge ref_clk);
	endtask
	task t_cmp;
		logic [3:0] want [4];
		want = '{4'h9, 4'h3, 4'h5, 4'h5};
		srcWordReg = 5'h1;
		secondOperandReg = 5'h2;
		for (int i = 0; i < 4; i++) begin
			crDestField = 3'(i);
			go(3'(i));
			`CHK(condFlags[28-4*i +: 4], want[i])
		end
		$display("compare test done");
	endtask
	task t_rot;
		srcWordReg = 5'h3;
		destReg = 5'h4;
		rfReadAddr = 5'h4;
		rotateAmountImm = 5'h10;
		maskBegin = 5'h10;
		maskEnd = 5'h17;
		recordFlag = 1;
		go(3'h4);
		`CHK(resultData, 32'h00001200)
		`CHK(rfReadData, 32'h00001200)
		`CHK(condFlags[31:28], 4'h5)
		secondOperandReg = 5'h5;
		maskBegin = 5'h18;
		maskEnd = 5'h7;
		recordFlag = 0;
		go(3'h5);
		`CHK(resultData, 32'h34000012)
		`CHK(condFlags[31:28], 4'h5)
		$display("rotate test done");
	endtask
	task t_edge;
		setSticky = 0;
		srcWordReg = 5'h2;
		immField = 16'h0003;
		crDestField = 3'h7;
		@(negedge ref_clk);
		go(3'h3);
		`CHK(condFlags[3:0], 4'h2)
		srcWordReg = 5'h3;
		rotateAmountImm = 5'h00;
		maskBegin = 5'h1f;
		maskEnd = 5'h1f;
		recordFlag = 1;
		go(3'h4);
		`CHK(resultData, 32'h00000000)
		`CHK(condFlags[31:28], 4'h2)
		rotateAmountImm = 5'h03;
		maskBegin = 5'h00;
		go(3'h4);
		`CHK(resultData, 32'h91a2b3c0)
		`CHK(rfReadData, 32'h91a2b3c0)
		`CHK(condFlags[31:28], 4'h8)
		go(3'h6);
		`CHK(resultData, 32'h91a2b3c0)
		`CHK(condFlags, 32'h83550002)
		$display("edge test done");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge ref_clk);
		rstn = 1;
		wr(5'h1, 32'hfffffffe);
		wr(5'h2, 32'h00000003);
		wr(5'h3, 32'h12345678);
		wr(5'h5, 32'h00000028);
		t_cmp();
		t_rot();
		t_edge();
		finish_test();
	end
endmodule
`default_nettype wire
